// File: verilog/ddc_map.svh
`ifndef DDC_MAP_SVH
`define DDC_MAP_SVH

// Command field and its patterns on control word bits 3..0.
`define DDC_CMD_LSB 0
`define DDC_CMD_OFF_MASK 4'h7
`define DDC_CMD_OFF 4'h6
`define DDC_CMD_ON 4'h7
`define DDC_CMD_ENABLE_OP 4'hF
// Control word bit positions.
`define DDC_CW_COAST_BIT 1
`define DDC_CW_QUICK_BIT 2
`define DDC_CW_REMOTE_BIT 10
// Status word bit positions.
`define DDC_SW_READY_BIT 0
`define DDC_SW_POWER_BIT 1
`define DDC_SW_OPER_BIT 2
`define DDC_SW_FAULT_BIT 3
`define DDC_SW_NO_COAST_BIT 4
`define DDC_SW_NO_QUICK_BIT 5
`define DDC_SW_INHIBIT_BIT 6
`define DDC_SW_REMOTE_BIT 9
`define DDC_SW_HOME_BIT 11
// Masks used by the master to identify the state.
`define DDC_STATE_MASK 16'h0277
`define DDC_STATE_MASK_SHORT 16'h0047
// Reset values.
`define DDC_STATUS_RESET 16'h0000
// Self-test duration after reset, in ns, and derived cycles at 25 MHz.
`define DDC_SELFTEST_NS 1000
`define DDC_CLK_NS 40
`define DDC_SELFTEST_CYC ((`DDC_SELFTEST_NS + `DDC_CLK_NS - 1) / `DDC_CLK_NS)

`endif

// File: verilog/ddc_pkg.sv
package ddc_pkg;
	typedef enum logic [5:0] {
		DDC_SELF_TEST = 6'h01,
		DDC_START_LOCKED = 6'h02,
		DDC_ARMED = 6'h04,
		DDC_POWER_ON = 6'h08,
		DDC_RUNNING = 6'h10,
		DDC_COASTING = 6'h20
	} ddc_state_t;
endpackage

// File: verilog/ddc_status_if.sv
interface ddc_status_if;
	ddc_pkg::ddc_state_t state;
	logic coast_active;
	logic quick_active;
	logic remote;
	logic fault;
	logic home_valid;
	logic [15:0] status_word;
	modport core (output state, output coast_active, output quick_active, output remote,
		output fault, output home_valid, input status_word);
	modport fmt (input state, input coast_active, input quick_active, input remote,
		input fault, input home_valid, output status_word);
endinterface

// File: verilog/ddc_status_fmt.sv
`include "ddc_map.svh"

module ddc_status_fmt (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// State from the sequencer
	ddc_status_if.fmt st
);
	logic [15:0] next_status;

	always_comb begin
		next_status = 16'h0000;
		case (st.state)
			ddc_pkg::DDC_START_LOCKED: next_status[`DDC_SW_INHIBIT_BIT] = 1'b1;
			ddc_pkg::DDC_ARMED: next_status[`DDC_SW_READY_BIT] = 1'b1;
			ddc_pkg::DDC_POWER_ON: begin
				next_status[`DDC_SW_READY_BIT] = 1'b1;
				next_status[`DDC_SW_POWER_BIT] = 1'b1;
			end
			ddc_pkg::DDC_RUNNING: begin
				next_status[`DDC_SW_READY_BIT] = 1'b1;
				next_status[`DDC_SW_POWER_BIT] = 1'b1;
				next_status[`DDC_SW_OPER_BIT] = 1'b1;
			end
			// Coast stop leaves the drive inhibited until the master releases it.
			ddc_pkg::DDC_COASTING: next_status[`DDC_SW_INHIBIT_BIT] = 1'b1;
			default: next_status = 16'h0000;
		endcase
		// Stop bits are reported apart from the state code.
		next_status[`DDC_SW_NO_COAST_BIT] = ~st.coast_active;
		next_status[`DDC_SW_NO_QUICK_BIT] = ~st.quick_active;
		next_status[`DDC_SW_FAULT_BIT] = st.fault;
		next_status[`DDC_SW_REMOTE_BIT] = st.remote;
		next_status[`DDC_SW_HOME_BIT] = st.home_valid;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st.status_word <= `DDC_STATUS_RESET;
		end else begin
			st.status_word <= next_status;
		end
	end
endmodule

// File: verilog/ddc_control_fsm.sv
// Functional notes
// - Self-test after reset, then start-locked, link up.
// - Start-locked keeps power stage off.
// - Start-locked to armed on enables and x110.
// - Armed waits for both enable inputs.
// - Armed plus 0111 enables power stage.
// - Power-on plus 1111 enters running.
// - Running keeps power stage and controller active.
// - Running plus 0111 ramps down to power-on.
// - Running plus x110 returns to armed.
// - Cleared bit 1 coasts, power stage off.
// - Any fault forces start-locked.
// - State read as status AND 0x0277.
// - Mask 0x0047 gives 0040, 0001, 0003, 0007.
// - Stop bits 4, 5 excluded from state.
// - Absolute encoder sets home valid directly.
// - Bits 4, 5 low while stops active.
// - Status bit 9 mirrors control bit 10.
// - Status bit 3 shows active fault.
`include "ddc_map.svh"

module ddc_control_fsm (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Cyclic frame from the fieldbus
	input wire logic frame_valid,
	input wire logic [15:0] control_word_param,
	// Drive inputs
	input wire logic power_stage_enable_input,
	input wire logic controller_enable_input,
	input wire logic fault_active,
	input wire logic absolute_encoder,
	input wire logic homing_done,
	input wire logic motor_at_standstill,
	// Status back to the fieldbus
	output logic [15:0] status_word_param,
	output logic link_active,
	// Drive outputs
	output logic power_stage_on,
	output logic controller_on,
	output logic stop_ramp_active,
	output logic coast_stop_cmd,
	output logic quick_stop_cmd
);
	localparam logic [5:0] SELFTEST_CYC = 6'(`DDC_SELFTEST_CYC);

	ddc_status_if st ();
	ddc_pkg::ddc_state_t state;
	ddc_pkg::ddc_state_t next_state;
	logic [5:0] selftest_count;
	logic [3:0] cmd;
	logic remote;
	logic enables;
	logic off_cmd;

	assign cmd = control_word_param[3:0];
	assign remote = control_word_param[`DDC_CW_REMOTE_BIT];
	assign enables = power_stage_enable_input & controller_enable_input;
	assign off_cmd = (cmd & `DDC_CMD_OFF_MASK) == `DDC_CMD_OFF;

	// Self-test runs with the link held down so the master sees no frames answered.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			selftest_count <= 6'h00;
		end else if (state == ddc_pkg::DDC_SELF_TEST) begin
			selftest_count <= selftest_count + 6'h01;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			ddc_pkg::DDC_SELF_TEST: begin
				if (selftest_count >= SELFTEST_CYC - 6'h01) begin
					next_state = ddc_pkg::DDC_START_LOCKED;
				end
			end
			ddc_pkg::DDC_START_LOCKED: begin
				if (enables && off_cmd) begin
					next_state = ddc_pkg::DDC_ARMED;
				end
			end
			ddc_pkg::DDC_ARMED: begin
				if (enables && cmd == `DDC_CMD_ON) begin
					next_state = ddc_pkg::DDC_POWER_ON;
				end
			end
			ddc_pkg::DDC_POWER_ON: begin
				if (cmd == `DDC_CMD_ENABLE_OP) begin
					next_state = ddc_pkg::DDC_RUNNING;
				end else if (off_cmd) begin
					next_state = ddc_pkg::DDC_ARMED;
				end
			end
			ddc_pkg::DDC_RUNNING: begin
				if (cmd == `DDC_CMD_ON) begin
					next_state = ddc_pkg::DDC_POWER_ON;
				end else if (off_cmd) begin
					next_state = ddc_pkg::DDC_ARMED;
				end
			end
			ddc_pkg::DDC_COASTING: begin
				if (off_cmd) begin
					next_state = ddc_pkg::DDC_START_LOCKED;
				end
			end
			default: next_state = ddc_pkg::DDC_SELF_TEST;
		endcase
		// Coast stop from any state except self-test overrides the command field.
		if (state != ddc_pkg::DDC_SELF_TEST && !control_word_param[`DDC_CW_COAST_BIT]) begin
			next_state = ddc_pkg::DDC_COASTING;
		end
	end

	// Commands count only on a frame with the remote bit set; others are ignored.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= ddc_pkg::DDC_SELF_TEST;
		end else if (state == ddc_pkg::DDC_SELF_TEST) begin
			state <= next_state;
		end else if (fault_active) begin
			state <= ddc_pkg::DDC_START_LOCKED;
		end else if (frame_valid && remote) begin
			state <= next_state;
		end
	end

	// Stop commands are latched per frame so the status reflects the last frame seen.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			coast_stop_cmd <= 1'b0;
			quick_stop_cmd <= 1'b0;
			st.remote <= 1'b0;
		end else if (frame_valid && state != ddc_pkg::DDC_SELF_TEST) begin
			coast_stop_cmd <= remote & ~control_word_param[`DDC_CW_COAST_BIT];
			quick_stop_cmd <= remote & ~control_word_param[`DDC_CW_QUICK_BIT];
			st.remote <= remote;
		end
	end

	// Power stage, controller and link outputs are registered from the state so they change together with the status word.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			power_stage_on <= 1'b0;
			controller_on <= 1'b0;
			link_active <= 1'b0;
		end else begin
			// Taken from the accepted state, never from a command that no frame carried.
			power_stage_on <= state == ddc_pkg::DDC_POWER_ON
				|| state == ddc_pkg::DDC_RUNNING;
			controller_on <= state == ddc_pkg::DDC_RUNNING;
			link_active <= state != ddc_pkg::DDC_SELF_TEST;
		end
	end

	// The emergency ramp runs after controller enabling is withdrawn from a moving drive.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			stop_ramp_active <= 1'b0;
		end else if (state == ddc_pkg::DDC_RUNNING && next_state != ddc_pkg::DDC_RUNNING
			&& next_state != ddc_pkg::DDC_COASTING
			&& frame_valid && remote && !fault_active) begin
			stop_ramp_active <= ~motor_at_standstill;
		end else if (fault_active && state == ddc_pkg::DDC_RUNNING) begin
			stop_ramp_active <= ~motor_at_standstill;
		end else if (motor_at_standstill || state == ddc_pkg::DDC_COASTING) begin
			stop_ramp_active <= 1'b0;
		end
	end

	assign st.state = state;
	assign st.coast_active = coast_stop_cmd;
	assign st.quick_active = quick_stop_cmd;
	assign st.fault = fault_active;
	assign st.home_valid = absolute_encoder | homing_done;

	ddc_status_fmt u_fmt (
		.ref_clk(ref_clk),
		.reset(reset),
		.st(st)
	);

	assign status_word_param = st.status_word;
endmodule

// File: dv/ddc_control_fsm_properties.sv
module ddc_control_fsm_properties (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Inputs
	input wire logic frame_valid,
	input wire logic fault_active,
	input wire logic power_stage_enable_input,
	input wire logic controller_enable_input,
	// Outputs
	input wire logic [15:0] status_word_param,
	input wire logic link_active,
	input wire logic power_stage_on,
	input wire logic controller_on
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic [15:0] sw;
	assign sw = status_word_param;
	chk_link_locked: assert property ($rose(link_active) |-> sw[6])
		else $error("link up outside start-locked");
	chk_locked_unpowered: assert property (sw[6] |-> !power_stage_on)
		else $error("power stage on while inhibited");
	chk_armed_enables: assert property ($rose(sw[0]) && !sw[1] |->
		$past(power_stage_enable_input, 2) && $past(controller_enable_input, 2))
		else $error("armed without enables");
	chk_run_powered: assert property ($rose(sw[2]) |-> power_stage_on && controller_on)
		else $error("running without power");
	chk_fault_locks: assert property ((fault_active && link_active) [*3] |->
		sw[6] && sw[3] && !power_stage_on)
		else $error("fault not locked");
	chk_fault_bit_clear: assert property ((!fault_active) [*3] |-> !sw[3])
		else $error("fault bit without fault");
	chk_coast_unpowered: assert property (link_active && !sw[4] |-> !power_stage_on)
		else $error("power on during coast stop");
	chk_state_code: assert property (link_active |->
		(sw & 16'h0047) inside {16'h0040, 16'h0001, 16'h0003, 16'h0007})
		else $error("illegal state code");
	chk_hold_quiet: assert property ((link_active && !fault_active && !frame_valid) [*3] |=>
		$stable(sw[6:0]))
		else $error("status moved without frame");
	cov_running: cover property ($rose(sw[2]));
	cov_coast: cover property (link_active && !sw[4]);
	cov_fault: cover property (fault_active && sw[3]);
endmodule

// File: dv/ddc_master_model.sv
module ddc_master_model (
	// Clock
	input wire logic ref_clk,
	// Cyclic frame
	output logic frame_valid,
	output logic [15:0] control_word_param
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		frame_valid = 1'b0;
		control_word_param = 16'h0000;
	end
	// The word is inverted between frames so a sample outside the frame cannot pass.
	task automatic send(input logic [15:0] cw);
		@(negedge ref_clk);
		frame_valid = 1'b1;
		control_word_param = cw;
		@(negedge ref_clk);
		frame_valid = 1'b0;
		control_word_param = ~cw;
		repeat (4) @(negedge ref_clk);
	endtask
endmodule

// File: dv/ddc_control_fsm_tb_top.sv
module ddc_control_fsm_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic pse = 1'b1, ce = 1'b1, fault = 1'b0, abs_enc = 1'b0, homed = 1'b0, still = 1'b1;
	logic frame_valid, link_active, ps_on, ctl_on, ramp, coast, quick;
	logic [15:0] cw, sw;
	logic [31:0] exp_q[$];
	logic [31:0] e;
	int fails = 0, n_compared = 0, cycles = 0;
	always #20 ref_clk = ~ref_clk;
	ddc_master_model u_ddc_master_model (.ref_clk(ref_clk), .frame_valid(frame_valid),
		.control_word_param(cw));
	ddc_control_fsm u_ddc_control_fsm (.ref_clk(ref_clk), .reset(reset), .frame_valid(frame_valid),
		.control_word_param(cw), .power_stage_enable_input(pse), .controller_enable_input(ce),
		.fault_active(fault), .absolute_encoder(abs_enc), .homing_done(homed),
		.motor_at_standstill(still), .status_word_param(sw), .link_active(link_active),
		.power_stage_on(ps_on), .controller_on(ctl_on), .stop_ramp_active(ramp),
		.coast_stop_cmd(coast), .quick_stop_cmd(quick));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (fails == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cmd(input logic [15:0] c, input logic [15:0] mask, input logic [15:0] exp);
		exp_q.push_back({mask, exp});
		u_ddc_master_model.send(c);
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			fails++;
			end_sim();
		end
	end
	// The status lands one edge after the frame edge; it is read at the falling edge after the second.
	initial forever begin
		@(posedge ref_clk iff frame_valid);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		e = exp_q.pop_front();
		check(sw & e[31:16], e[15:0]);
	end
	initial begin
		logic [15:0] r;
		r = $urandom(32'h953DB2DF);
		repeat (8) @(negedge ref_clk);
		reset = 1'b0;
		wait (link_active === 1'b1);
		@(negedge ref_clk);
		check(sw & 16'h0277, 16'h0070);
		check({15'h0000, ps_on}, 16'h0000);
		r = $urandom;
		cmd({12'h040, r[3], 3'h6}, 16'h0277, 16'h0231);
		cmd(16'h040F, 16'h0277, 16'h0231);
		cmd(16'h0007, 16'h0277, 16'h0031);
		cmd(16'h040B, 16'h0277, 16'h0211);
		check({15'h0000, quick}, 16'h0001);
		cmd(16'h0407, 16'h0277, 16'h0233);
		check({15'h0000, ps_on}, 16'h0001);
		cmd(16'h040F, 16'h0277, 16'h0237);
		check({15'h0000, ctl_on}, 16'h0001);
		still = 1'b0;
		cmd(16'h0407, 16'h0277, 16'h0233);
		check({15'h0000, ramp}, 16'h0001);
		still = 1'b1;
		@(negedge ref_clk);
		check({15'h0000, ramp}, 16'h0000);
		cmd(16'h040F, 16'h0277, 16'h0237);
		r = $urandom;
		cmd({12'h040, r[3], 3'h6}, 16'h0277, 16'h0231);
		cmd(16'h0405, 16'h0057, 16'h0040);
		check({15'h0000, ps_on}, 16'h0000);
		check({15'h0000, coast}, 16'h0001);
		cmd(16'h0406, 16'h0277, 16'h0270);
		ce = 1'b0;
		cmd(16'h0406, 16'h0277, 16'h0270);
		ce = 1'b1;
		cmd(16'h0406, 16'h0277, 16'h0231);
		cmd(16'h0407, 16'h0277, 16'h0233);
		cmd(16'h040F, 16'h0277, 16'h0237);
		fault = 1'b1;
		abs_enc = 1'b1;
		repeat (4) @(negedge ref_clk);
		check(sw & 16'h0A7F, 16'h0A78);
		fault = 1'b0;
		repeat (4) @(negedge ref_clk);
		check(sw & 16'h0008, 16'h0000);
		end_sim();
	end
endmodule
bind ddc_control_fsm ddc_control_fsm_properties u_ddc_control_fsm_properties (
	.ref_clk(ref_clk), .reset(reset), .frame_valid(frame_valid), .fault_active(fault_active),
	.power_stage_enable_input(power_stage_enable_input),
	.controller_enable_input(controller_enable_input), .status_word_param(status_word_param),
	.link_active(link_active), .power_stage_on(power_stage_on), .controller_on(controller_on));
